/* src/oms_config_bank.sv */
// Output mux, output stop and multi-purpose pin configuration register group.
// Assumes a single-cycle register port in the clk domain and an external status bank.
// How it works
// - Mux code picks PLL integer or fractional path
// - Groups D E F in second mux register
// - Stop bit stops output when source 0001
// - Internal stop is stop bit OR global
// - Pin config nibbles: odd pin high, even low
// - Codes 0000/0001 are plain or inverted input
// - Codes 0010/0011 drive pin low or high
// - Codes 01xx make pin follow a status bit
// - Pin level always readable as pin state
// - Status select used only in 01xx modes
// - Followed bit at 0x40 plus field, bit
// - Unimplemented status selection is followed as a low status bit
// - Pin status and PLL enables never followed
// - Four status selects at 0x0d..0x10, reset zero
// - Reset loads address defaults; mode pins land on the third edge after release
// - Hard and soft reset keep slave address
// - Global stop halts outputs with source 0001
`timescale 1ns/1ps
module oms_config_bank #(
  parameter logic [oms_pkg::NUM_STATUS_REGS*8-1:0] STATUS_IMPL = '1,
  parameter logic [4:0] PLL1_IE_IDX = 5'h1e,
  parameter logic [4:0] PLL2_IE_IDX = 5'h1f
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [oms_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [oms_pkg::DATA_W-1:0] reg_wdata,
  output logic [oms_pkg::DATA_W-1:0] reg_rdata,
  // Device-level resets
  input wire logic hard_reset_bit,
  input wire logic soft_reset_bit,
  // Output stop
  input wire logic global_output_stop,
  input wire logic [oms_pkg::NUM_OUTS-1:0][3:0] stop_source_select,
  output logic [oms_pkg::NUM_OUTS-1:0] out_stop,
  // Output group sources
  output logic [1:0] group_a_source,
  output logic [1:0] group_b_source,
  output logic [1:0] group_c_source,
  output logic [1:0] group_d_source,
  output logic [1:0] group_e_source,
  output logic [1:0] group_f_source,
  // Multi-purpose pins
  input wire logic [oms_pkg::NUM_PINS-1:0] pin_i,
  output logic [oms_pkg::NUM_PINS-1:0] pin_o,
  output logic [oms_pkg::NUM_PINS-1:0] pin_oe,
  output logic [oms_pkg::NUM_PINS-1:0] pin_in_value,
  output logic [oms_pkg::NUM_PINS-1:0] pin_state,
  // Status bank to follow
  input wire logic [oms_pkg::NUM_STATUS_REGS-1:0][7:0] status_regs,
  // Serial slave address
  input wire logic interface_mode_pin_1,
  input wire logic interface_mode_pin_0,
  output logic [6:0] serial_slave_address
);
  import oms_pkg::*;

  if (PLL1_IE_IDX == PIN_STATUS_REG_IDX || PLL2_IE_IDX == PIN_STATUS_REG_IDX) begin : g_bad_idx
    $error("PLL enable register index collides with pin status register");
  end

  typedef struct packed {
    logic [5:0] mux1;
    logic [5:0] mux2;
    logic [7:0] stop1;
    logic [STOP2_W-1:0] stop2;
    logic [NUM_PINS-1:0][3:0] pcfg;
    logic [NUM_PINS-1:0][7:0] sel;
    logic [6:0] slave;
    logic [1:0] strap_wait;
    logic [NUM_PINS-1:0] pin_s1;
    logic [NUM_PINS-1:0] pin_s2;
    logic [1:0] ifp_s1;
    logic [1:0] ifp_s2;
    logic [7:0] rdata;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_en;
    logic [NUM_PINS-1:0] pin_val;
    logic [NUM_OUTS-1:0] stop_out;
  } oms_state_t;

  oms_state_t q;
  oms_state_t d;

  logic [NUM_STATUS_REGS*8-1:0] status_flat;
  logic [NUM_PINS-1:0] follow_bit;
  logic [NUM_PINS-1:0] cell_drive;
  logic [NUM_PINS-1:0] cell_en;
  logic [NUM_PINS-1:0] cell_val;
  logic [NUM_OUTS-1:0] stop_bits;

  assign status_flat = status_regs;
  assign stop_bits = {q.stop2, q.stop1};

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [4:0] reg_idx;
    logic blocked;
    assign reg_idx = q.sel[p][SEL_REG_LSB +: SEL_REG_W];
    // Pin status and PLL enable bytes would make a pin loop on itself
    assign blocked = (reg_idx == PIN_STATUS_REG_IDX) || (reg_idx == PLL1_IE_IDX) ||
                     (reg_idx == PLL2_IE_IDX);
    // Select byte is register*8 + bit, so it indexes the flat bank directly
    assign follow_bit[p] = status_flat[q.sel[p]] & STATUS_IMPL[q.sel[p]] &
                           ~blocked;

    oms_pin_cell u_cell (
      .cfg(q.pcfg[p]),
      .status_bit(follow_bit[p]),
      .level(q.pin_s2[p]),
      .drive(cell_drive[p]),
      .drive_en(cell_en[p]),
      .in_value(cell_val[p])
    );
  end

  always_comb begin
    logic [7:0] rd_val;
    rd_val = REG_RST;
    d = q;

    // Two-stage synchronisers for pins and mode straps
    d.pin_s1 = pin_i;
    d.pin_s2 = q.pin_s1;
    d.ifp_s1 = {interface_mode_pin_1, interface_mode_pin_0};
    d.ifp_s2 = q.ifp_s1;

    // Strap capture once the synchronised mode pins have settled
    if (q.strap_wait != STRAP_DONE) begin
      d.strap_wait = q.strap_wait + 2'h1;
    end
    if (q.strap_wait == STRAP_LOAD) begin
      d.slave[SLAVE_STRAP_W-1:0] = q.ifp_s2;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MUX_1: d.mux1 = reg_wdata[5:0];
        ADDR_MUX_2: d.mux2 = reg_wdata[5:0];
        ADDR_STOP_1: d.stop1 = reg_wdata;
        ADDR_STOP_2: d.stop2 = reg_wdata[STOP2_W-1:0];
        ADDR_PCFG_1: begin
          d.pcfg[0] = reg_wdata[PCFG_EVEN_LSB +: CFG_W];
          d.pcfg[1] = reg_wdata[PCFG_ODD_LSB +: CFG_W];
        end
        ADDR_PCFG_2: begin
          d.pcfg[2] = reg_wdata[PCFG_EVEN_LSB +: CFG_W];
          d.pcfg[3] = reg_wdata[PCFG_ODD_LSB +: CFG_W];
        end
        ADDR_SEL_0: d.sel[0] = reg_wdata;
        ADDR_SEL_1: d.sel[1] = reg_wdata;
        ADDR_SEL_2: d.sel[2] = reg_wdata;
        ADDR_SEL_3: d.sel[3] = reg_wdata;
        // No guard against zero: keeping the address legal is software's job
        ADDR_SLAVE: d.slave = reg_wdata[6:0];
        default: d.slave = d.slave;
      endcase
    end

    // Hard and soft reset clear configuration but leave the address alone
    if (hard_reset_bit || soft_reset_bit) begin
      d.mux1 = REG_RST[5:0];
      d.mux2 = REG_RST[5:0];
      d.stop1 = REG_RST;
      d.stop2 = REG_RST[STOP2_W-1:0];
      d.pcfg = '0;
      d.sel = '0;
    end

    // Read path, registered
    case (reg_addr)
      ADDR_MUX_1: rd_val = {2'h0, q.mux1};
      ADDR_MUX_2: rd_val = {2'h0, q.mux2};
      ADDR_STOP_1: rd_val = q.stop1;
      ADDR_STOP_2: rd_val = {6'h00, q.stop2};
      ADDR_PCFG_1: rd_val = {q.pcfg[1], q.pcfg[0]};
      ADDR_PCFG_2: rd_val = {q.pcfg[3], q.pcfg[2]};
      ADDR_SEL_0: rd_val = q.sel[0];
      ADDR_SEL_1: rd_val = q.sel[1];
      ADDR_SEL_2: rd_val = q.sel[2];
      ADDR_SEL_3: rd_val = q.sel[3];
      ADDR_SLAVE: rd_val = {1'b0, q.slave};
      default: rd_val = REG_RST;
    endcase
    if (reg_rd) begin
      d.rdata = rd_val;
    end

    // Pin drive, one register stage so outputs come from flops
    d.pin_out = cell_drive;
    d.pin_en = cell_en;
    d.pin_val = cell_val;

    // Internal stop controls
    for (int i = 0; i < NUM_OUTS; i++) begin
      d.stop_out[i] = (stop_source_select[i] == STOP_SRC_REG) &&
                      (stop_bits[i] || global_output_stop);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.slave <= {SLAVE_RST_HI, 2'h0};
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign out_stop = q.stop_out;
  assign group_a_source = q.mux1[MUX_LO_LSB +: MUX_W];
  assign group_b_source = q.mux1[MUX_MID_LSB +: MUX_W];
  assign group_c_source = q.mux1[MUX_HI_LSB +: MUX_W];
  assign group_d_source = q.mux2[MUX_LO_LSB +: MUX_W];
  assign group_e_source = q.mux2[MUX_MID_LSB +: MUX_W];
  assign group_f_source = q.mux2[MUX_HI_LSB +: MUX_W];
  assign pin_o = q.pin_out;
  assign pin_oe = q.pin_en;
  assign pin_in_value = q.pin_val;
  assign pin_state = q.pin_s2;
  assign serial_slave_address = q.slave;
endmodule

/* src/oms_pkg.sv */
// Constants for the output mux, stop and pin configuration register group.
// Assumes an 8-bit processor register port with 7-bit addresses on one core clock.
package oms_pkg;
  localparam int NUM_PINS = 4;
  localparam int NUM_OUTS = 10;
  localparam int NUM_STATUS_REGS = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CFG_W = 4;
  localparam int MUX_W = 2;

  // Register offsets
  localparam logic [6:0] ADDR_MUX_1 = 7'h07;
  localparam logic [6:0] ADDR_MUX_2 = 7'h08;
  localparam logic [6:0] ADDR_STOP_1 = 7'h09;
  localparam logic [6:0] ADDR_STOP_2 = 7'h0a;
  localparam logic [6:0] ADDR_PCFG_1 = 7'h0b;
  localparam logic [6:0] ADDR_PCFG_2 = 7'h0c;
  localparam logic [6:0] ADDR_SEL_0 = 7'h0d;
  localparam logic [6:0] ADDR_SEL_1 = 7'h0e;
  localparam logic [6:0] ADDR_SEL_2 = 7'h0f;
  localparam logic [6:0] ADDR_SEL_3 = 7'h10;
  localparam logic [6:0] ADDR_SLAVE = 7'h11;

  // Mux field positions inside each mux register
  localparam int MUX_LO_LSB = 0;
  localparam int MUX_MID_LSB = 2;
  localparam int MUX_HI_LSB = 4;

  // Path codes of a mux field
  localparam logic [1:0] SRC_PLL1_INT = 2'h0;
  localparam logic [1:0] SRC_PLL1_FRAC = 2'h1;
  localparam logic [1:0] SRC_PLL2_INT = 2'h2;
  localparam logic [1:0] SRC_PLL2_FRAC = 2'h3;

  // Stop
  localparam int STOP2_W = 2;
  localparam logic [3:0] STOP_SRC_REG = 4'h1;

  // Pin configuration nibbles and codes
  localparam int PCFG_EVEN_LSB = 0;
  localparam int PCFG_ODD_LSB = 4;
  localparam logic [3:0] CFG_IN = 4'h0;
  localparam logic [3:0] CFG_IN_INV = 4'h1;
  localparam logic [3:0] CFG_OUT_LOW = 4'h2;
  localparam logic [3:0] CFG_OUT_HIGH = 4'h3;
  localparam logic [3:0] CFG_ST = 4'h4;
  localparam logic [3:0] CFG_ST_INV = 4'h5;
  localparam logic [3:0] CFG_ST_LOW0 = 4'h6;
  localparam logic [3:0] CFG_ST_LOW1 = 4'h7;

  // Status select layout
  localparam int SEL_REG_LSB = 3;
  localparam int SEL_REG_W = 5;
  localparam int SEL_BIT_W = 3;
  localparam logic [6:0] STATUS_BASE = 7'h40;
  localparam logic [4:0] PIN_STATUS_REG_IDX = 5'h01;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [4:0] SLAVE_RST_HI = 5'h1d;
  localparam int SLAVE_STRAP_W = 2;

  // Strap capture timing after reset release, in clock edges
  localparam logic [1:0] STRAP_LOAD = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
endpackage

/* src/oms_pin_cell.sv */
// One multi-purpose pin: decodes its configuration into drive and input value.
// Assumes a synchronised pin level and an already-qualified status bit.
`timescale 1ns/1ps
module oms_pin_cell (
  // Configuration
  input wire logic [3:0] cfg,
  input wire logic status_bit,
  // Pin
  input wire logic level,
  output logic drive,
  output logic drive_en,
  // Input value seen by the core
  output logic in_value
);
  import oms_pkg::*;

  always_comb begin
    drive = 1'b0;
    drive_en = 1'b0;
    in_value = level;
    case (cfg)
      CFG_IN: in_value = level;
      CFG_IN_INV: in_value = ~level;
      CFG_OUT_LOW: begin
        drive = 1'b0;
        drive_en = 1'b1;
      end
      CFG_OUT_HIGH: begin
        drive = 1'b1;
        drive_en = 1'b1;
      end
      CFG_ST: begin
        drive = status_bit;
        drive_en = 1'b1;
      end
      CFG_ST_INV: begin
        drive = ~status_bit;
        drive_en = 1'b1;
      end
      CFG_ST_LOW0: drive_en = ~status_bit;
      CFG_ST_LOW1: drive_en = status_bit;
      // Unused codes leave the pin a plain input, the least harmful choice
      default: drive_en = 1'b0;
    endcase
  end
endmodule

/* tb/oms_config_bank_asserts.sv */
// Port-level checks for the config bank, bound to its top module.
// Assumes inputs move between clock edges.
`timescale 1ns/1ps
module oms_cb_chk (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Controls
  input wire logic hard_reset_bit,
  input wire logic soft_reset_bit,
  input wire logic global_output_stop,
  input wire logic [9:0][3:0] stop_source_select,
  // Results
  input wire logic [9:0] out_stop,
  input wire logic [1:0] group_d_source,
  input wire logic [1:0] group_e_source,
  input wire logic [1:0] group_f_source,
  input wire logic [3:0] pin_i,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_state,
  input wire logic [6:0] serial_slave_address
);
  logic [9:0] src1;
  logic [1:0] age_q;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      src1[i] = (stop_source_select[i] == 4'h1);
    end
  end
  // Strap load lands on the third edge, so the address may move until then
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_STOP_SRC: assert property ((out_stop & ~$past(src1)) == 10'h0)
    else $error("stop without source 0001");
  AST_GLOBAL_STOP: assert property (
    global_output_stop |=> (out_stop & $past(src1)) == $past(src1))
    else $error("global stop missed");
  AST_DRIVE_EN: assert property ((pin_o & ~pin_oe) == 4'h0)
    else $error("pin high without enable");
  // Both earlier edges must be out of reset, or a mid-run reset trips it
  AST_PIN_STATE: assert property (
    !$past(rst) && !$past(rst, 2) |-> pin_state == $past(pin_i, 2))
    else $error("pin state lags");
  AST_ADDR_KEEP: assert property (
    age_q == 2'h3 && !(reg_wr && reg_addr == 7'h11) |=> $stable(serial_slave_address))
    else $error("slave address moved");
  AST_MUX2_WRITE: assert property (
    reg_wr && reg_addr == 7'h08 && !hard_reset_bit && !soft_reset_bit
    |=> {2'h0, group_f_source, group_e_source, group_d_source} == ($past(reg_wdata) & 8'h3f))
    else $error("mux 2 write lost");
  AST_SOFT_CLEAR: assert property (
    soft_reset_bit |=> {group_f_source, group_e_source, group_d_source} == 6'h0)
    else $error("soft clear missed");
  AST_UNMAPPED_RD: assert property (
    reg_rd && (reg_addr < 7'h07 || reg_addr > 7'h11) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (global_output_stop ##1 out_stop != 10'h0);
  cover property (hard_reset_bit);
  cover property (reg_wr && reg_addr == 7'h08);
endmodule
bind oms_config_bank oms_cb_chk i_oms_cb_chk (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hard_reset_bit(hard_reset_bit),
  .soft_reset_bit(soft_reset_bit), .global_output_stop(global_output_stop),
  .stop_source_select(stop_source_select), .out_stop(out_stop), .group_d_source(group_d_source),
  .group_e_source(group_e_source), .group_f_source(group_f_source), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe(pin_oe), .pin_state(pin_state),
  .serial_slave_address(serial_slave_address)
);

/* tb/oms_config_bank_tb.sv */
// Self-checking bench for the output mux, stop and pin config bank.
// Assumes the note's register port timing; inputs move on falling edges.
`timescale 1ns/1ps
module oms_config_bank_tb;
  import oms_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} oms_row_t;
  typedef struct packed {logic [7:0] c1; logic [7:0] c2; logic [7:0] oe_o;} oms_pin_row_t;
  localparam oms_row_t ROWS [12] = '{
    '{7'h07, 8'hff, 8'h3f}, '{7'h08, 8'hff, 8'h3f}, '{7'h09, 8'ha5, 8'ha5},
    '{7'h0a, 8'hff, 8'h03}, '{7'h0b, 8'h47, 8'h47}, '{7'h0c, 8'h76, 8'h76},
    '{7'h0d, 8'hff, 8'hff}, '{7'h0e, 8'h01, 8'h01}, '{7'h0f, 8'h80, 8'h80},
    '{7'h10, 8'h13, 8'h13}, '{7'h05, 8'hff, 8'h00}, '{7'h12, 8'hff, 8'h00}};
  localparam oms_pin_row_t PINS [4] = '{
    '{8'h32, 8'h54, 8'hfa}, '{8'h54, 8'h54, 8'hf9},
    '{8'h76, 8'h54, 8'he8}, '{8'h10, 8'h54, 8'hc8}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, hard_reset_bit = 1'b0, soft_reset_bit = 1'b0;
  logic global_output_stop = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [9:0][3:0] stop_source_select = {4'h2, {9{4'h1}}};
  logic [31:0][7:0] status_regs = '0;
  logic [3:0] pin_ext = 4'h1;
  logic [1:0] ifp = 2'h2;
  logic [3:0] pin_i, pin_o, pin_oe, pin_in_value, pin_state;
  logic [7:0] reg_rdata;
  logic [9:0] out_stop;
  logic [1:0] ga, gb, gc, gd, ge, gf;
  logic [6:0] slave;
  int error_cnt = 0;
  int checked = 0;
  // Wire level: the design wins where it drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_ext);
  always #4 clk = ~clk;
  // Byte 2 bit 4 left unimplemented so a dead selection is exercised
  oms_config_bank #(.STATUS_IMPL(~(256'h1 << 20))) i_oms_config_bank (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hard_reset_bit(hard_reset_bit),
    .soft_reset_bit(soft_reset_bit), .global_output_stop(global_output_stop),
    .stop_source_select(stop_source_select), .out_stop(out_stop), .group_a_source(ga),
    .group_b_source(gb), .group_c_source(gc), .group_d_source(gd), .group_e_source(ge),
    .group_f_source(gf), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_in_value(pin_in_value), .pin_state(pin_state), .status_regs(status_regs),
    .interface_mode_pin_1(ifp[1]), .interface_mode_pin_0(ifp[0]), .serial_slave_address(slave));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic summarize();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(negedge clk);
    chk(16'(slave), 16'h0074);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(ADDR_SLAVE, 8'h76);
    // Pin codes stay within 0..7
    foreach (ROWS[i]) begin
      rd(ROWS[i].a, 8'h00);
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    wr(ADDR_MUX_1, 8'h1b);
    wr(ADDR_MUX_2, 8'h24);
    chk(16'({gc, gb, ga, gf, ge, gd}), 16'h06e4);
    wr(ADDR_STOP_1, 8'h81);
    wr(ADDR_STOP_2, 8'h02);
    @(negedge clk);
    chk(16'(out_stop), 16'h0081);
    global_output_stop = 1'b1;
    @(negedge clk);
    chk(16'(out_stop), 16'h01ff);
    global_output_stop = 1'b0;
    status_regs[1] = 8'hff;
    // Bit 4 is set but unimplemented, so pin 3 follows a low and, inverted, drives high
    status_regs[2] = 8'h18;
    wr(ADDR_SEL_0, 8'h13);
    wr(ADDR_SEL_1, 8'h13);
    wr(ADDR_SEL_2, 8'h0b);
    wr(ADDR_SEL_3, 8'h14);
    foreach (PINS[i]) begin
      wr(ADDR_PCFG_1, PINS[i].c1);
      wr(ADDR_PCFG_2, PINS[i].c2);
      repeat (4) @(negedge clk);
      chk(16'({pin_oe, pin_o}), 16'(PINS[i].oe_o));
    end
    chk(16'({pin_state, pin_in_value[1:0]}), 16'h0027);
    // Address never written as zero
    wr(ADDR_SLAVE, 8'h2a);
    hard_reset_bit = 1'b1;
    @(negedge clk);
    hard_reset_bit = 1'b0;
    soft_reset_bit = 1'b1;
    @(negedge clk);
    soft_reset_bit = 1'b0;
    chk(16'(slave), 16'h002a);
    rd(ADDR_PCFG_1, 8'h00);
    // New strap levels must land on the second release
    rst = 1'b1;
    ifp = 2'h1;
    @(negedge clk);
    chk(16'(slave), 16'h0074);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(slave), 16'h0075);
    summarize();
  end
endmodule
